// ===== agc_control.sv
`timescale 1ns/10ps
module agc_control
  import agc_pkg::*;
#(
  parameter int TIMEOUT = ZC_TIMEOUT_MCLKS,
  parameter int FILT_INIT = FILT_INIT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [15:0] wrWord,
  input wire logic wrStrobe,
  input wire logic frameClkIn,
  input wire logic bitClkIn,
  input wire logic [23:0] leftSample,
  input wire logic [23:0] rightSample,
  input wire logic sampleValid,
  output logic frameClkOut,
  output logic frameClkOe,
  output logic bitClkOut,
  output logic bitClkOe,
  output logic frameSync,
  output logic bitClkSync,
  output logic oversample64,
  output logic refPowerDown,
  output logic converterPowerDown,
  output logic inputStagePowerDown,
  output logic filterClear,
  output logic filterReady,
  output logic highpassBypass,
  output logic [7:0] leftAnalogCode,
  output logic [7:0] rightAnalogCode,
  output logic [7:0] leftDigitalCode,
  output logic [7:0] rightDigitalCode,
  output logic leftSilence,
  output logic rightSilence
);
  // ****************************************
  // Register file
  // ****************************************
  logic [8:0] zcCtl_ff, filtCtl_ff, clkCtl_ff, pwrCtl_ff, gainL_ff, gainR_ff, muteLink_ff;
  logic [6:0] wrAddr;
  logic [8:0] wrData;
  assign wrAddr = wrWord[15:9];
  assign wrData = wrWord[8:0];

  // Registers survive power-down; only reset clears them
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      zcCtl_ff <= RST_ZC_TIMEOUT;
      filtCtl_ff <= RST_FILTER;
      clkCtl_ff <= RST_CLOCKING;
      pwrCtl_ff <= RST_POWER;
      gainL_ff <= RST_GAIN;
      gainR_ff <= RST_GAIN;
      muteLink_ff <= RST_MUTE_LINK;
    end else if (wrStrobe) begin
      unique case (wrAddr)
        ADDR_ZC_TIMEOUT: zcCtl_ff <= wrData;
        ADDR_FILTER: filtCtl_ff <= wrData;
        ADDR_CLOCKING: clkCtl_ff <= wrData;
        ADDR_POWER: pwrCtl_ff <= wrData;
        ADDR_LEFT_GAIN: gainL_ff <= wrData;
        ADDR_RIGHT_GAIN: gainR_ff <= wrData;
        ADDR_MUTE_LINK: muteLink_ff <= wrData;
        default: ;
      endcase
    end
  end

  logic masterSel, globalPd, convDis, linkSel;
  assign masterSel = clkCtl_ff[MS_BIT];
  assign globalPd = pwrCtl_ff[GLOBAL_POWERDOWN_BIT];
  assign convDis = pwrCtl_ff[CONVERTER_DISABLE_BIT];
  assign linkSel = muteLink_ff[LINK_BIT];

  // ****************************************
  // Clock pin synchronisers (slave mode)
  // ****************************************
  logic [1:0] frameSyn_ff, bitSyn_ff;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      frameSyn_ff <= 2'h0;
      bitSyn_ff <= 2'h0;
    end else begin
      frameSyn_ff <= {frameSyn_ff[0], frameClkIn};
      bitSyn_ff <= {bitSyn_ff[0], bitClkIn};
    end
  end

  // ****************************************
  // Master-mode clock divider
  // ****************************************
  function automatic logic [9:0] ratioDiv(input logic [2:0] code);
    unique case (code)
      RATE_384: ratioDiv = 10'(FS_DIV_384);
      RATE_512: ratioDiv = 10'(FS_DIV_512);
      RATE_768: ratioDiv = 10'(FS_DIV_768);
      default: ratioDiv = 10'(FS_DIV_256);
    endcase
  endfunction : ratioDiv

  logic [9:0] frameDiv;
  logic [9:0] divCnt_ff;
  logic [3:0] bitStep;
  assign frameDiv = ratioDiv(clkCtl_ff[RATE_LSB+2:RATE_LSB]);
  // Bit clock period = frame / 64; ratios give 4, 6, 8, 12 clocks per bit
  assign bitStep = 4'(frameDiv / 10'(BCLK_PER_FRAME));

  logic [3:0] bitCnt_ff;
  always_ff @(posedge ref_clk) begin
    if (!rst_b || !masterSel || globalPd) begin
      divCnt_ff <= '0;
      bitCnt_ff <= '0;
    end else begin
      divCnt_ff <= (divCnt_ff >= frameDiv - 10'h1) ? 10'h0 : divCnt_ff + 10'h1;
      bitCnt_ff <= (bitCnt_ff >= bitStep - 4'h1) ? 4'h0 : bitCnt_ff + 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      frameClkOut <= 1'b0;
      bitClkOut <= 1'b0;
      frameClkOe <= 1'b0;
      bitClkOe <= 1'b0;
      frameSync <= 1'b0;
      bitClkSync <= 1'b0;
    end else begin
      frameClkOe <= masterSel;
      bitClkOe <= masterSel;
      frameClkOut <= masterSel && (divCnt_ff < (frameDiv >> 1));
      bitClkOut <= masterSel && (bitCnt_ff < (bitStep >> 1));
      frameSync <= masterSel ? (divCnt_ff < (frameDiv >> 1)) : frameSyn_ff[1];
      bitClkSync <= masterSel ? (bitCnt_ff < (bitStep >> 1)) : bitSyn_ff[1];
    end
  end

  // ****************************************
  // Power and filter sequencing
  // ****************************************
  logic [7:0] initCnt_ff;
  logic haltPath;
  assign haltPath = globalPd || convDis;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      refPowerDown <= 1'b0;
      converterPowerDown <= 1'b0;
      inputStagePowerDown <= 1'b0;
      oversample64 <= 1'b0;
      highpassBypass <= 1'b0;
    end else begin
      refPowerDown <= globalPd;
      converterPowerDown <= haltPath;
      inputStagePowerDown <= globalPd || pwrCtl_ff[INPUT_STAGE_DISABLE_BIT];
      oversample64 <= clkCtl_ff[OSR_BIT];
      highpassBypass <= filtCtl_ff[HPD_BIT];
    end
  end

  // Filters held clear while halted, then need an init run before output
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      initCnt_ff <= '0;
      filterClear <= 1'b1;
      filterReady <= 1'b0;
    end else if (haltPath) begin
      initCnt_ff <= '0;
      filterClear <= 1'b1;
      filterReady <= 1'b0;
    end else begin
      filterClear <= 1'b0;
      if (initCnt_ff < 8'(FILT_INIT)) begin
        initCnt_ff <= initCnt_ff + 8'h1;
      end
      filterReady <= initCnt_ff >= 8'(FILT_INIT - 1);
    end
  end

  // ****************************************
  // Gain channels with zero-cross update
  // ****************************************
  agc_gain_if giL ();
  agc_gain_if giR ();
  logic [8:0] rightSrc;
  assign rightSrc = linkSel ? gainL_ff : gainR_ff;
  logic wrL, wrR, wrLink;
  assign wrL = wrStrobe && wrAddr == ADDR_LEFT_GAIN;
  assign wrR = wrStrobe && wrAddr == ADDR_RIGHT_GAIN;
  assign wrLink = wrStrobe && wrAddr == ADDR_MUTE_LINK;
  logic loadL_ff, loadR_ff;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      loadL_ff <= 1'b0;
      loadR_ff <= 1'b0;
    end else begin
      loadL_ff <= wrL;
      loadR_ff <= linkSel ? (wrL || wrLink) : (wrR || wrLink);
    end
  end

  assign giL.reqCode = gainL_ff[7:0];
  assign giL.reqLoad = loadL_ff;
  assign giL.reqZc = gainL_ff[ZC_BIT];
  assign giL.timeoutDis = zcCtl_ff[TOD_BIT];
  assign giL.sample = leftSample;
  assign giL.sampleValid = sampleValid && !globalPd;
  assign giR.reqCode = rightSrc[7:0];
  assign giR.reqLoad = loadR_ff;
  assign giR.reqZc = gainR_ff[ZC_BIT];
  assign giR.timeoutDis = zcCtl_ff[TOD_BIT];
  assign giR.sample = rightSample;
  assign giR.sampleValid = sampleValid && !globalPd;

  agc_zc_channel #(.TIMEOUT(TIMEOUT)) uChanL (.ref_clk(ref_clk), .rst_b(rst_b), .gi(giL));
  agc_zc_channel #(.TIMEOUT(TIMEOUT)) uChanR (.ref_clk(ref_clk), .rst_b(rst_b), .gi(giR));

  // Split one code into analogue step and digital attenuation
  function automatic logic [7:0] analogOf(input logic [7:0] c);
    analogOf = (c >= GAIN_MIN_ANALOG) ? c - GAIN_MIN_ANALOG : 8'h00;
  endfunction : analogOf
  function automatic logic [7:0] digitalOf(input logic [7:0] c);
    digitalOf = (c >= GAIN_MIN_ANALOG) ? 8'h00 : GAIN_MIN_ANALOG - c;
  endfunction : digitalOf

  // Same controls feed converted and bypass paths alike
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      leftAnalogCode <= analogOf(RST_GAIN[7:0]);
      rightAnalogCode <= analogOf(RST_GAIN[7:0]);
      leftDigitalCode <= 8'h00;
      rightDigitalCode <= 8'h00;
      leftSilence <= 1'b0;
      rightSilence <= 1'b0;
    end else begin
      leftAnalogCode <= analogOf(giL.curCode);
      rightAnalogCode <= analogOf(giR.curCode);
      leftDigitalCode <= digitalOf(giL.curCode);
      rightDigitalCode <= digitalOf(giR.curCode);
      leftSilence <= muteLink_ff[MUTEL_BIT] || giL.curCode == GAIN_MUTE_CODE;
      rightSilence <= muteLink_ff[MUTER_BIT] || giR.curCode == GAIN_MUTE_CODE;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_pdWrite;
    wrStrobe && wrAddr == ADDR_POWER && wrData[GLOBAL_POWERDOWN_BIT];
  endsequence
  sequence s_pdRelease;
    globalPd ##1 !globalPd && !convDis;
  endsequence
  property p_master_drive;
    @(posedge ref_clk) disable iff (!rst_b) masterSel |=> frameClkOe && bitClkOe;
  endproperty
  a_master_drive: assert property (p_master_drive) else $error("master pins not driven");
  property p_slave_release;
    @(posedge ref_clk) disable iff (!rst_b) !masterSel |=> !frameClkOe && !bitClkOe;
  endproperty
  a_slave_release: assert property (p_slave_release) else $error("slave drives clocks");
  property p_frame_period;
    @(posedge ref_clk) disable iff (!rst_b)
      masterSel && !globalPd && divCnt_ff == 10'h0 && $stable(frameDiv) |=> divCnt_ff == 10'h1;
  endproperty
  a_frame_period: assert property (p_frame_period) else $error("divider stalled");
  property p_ratio;
    @(posedge ref_clk) disable iff (!rst_b)
      clkCtl_ff[2:0] == RATE_384 |-> frameDiv == 10'(FS_DIV_384);
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio decode wrong");
  property p_osr;
    @(posedge ref_clk) disable iff (!rst_b) ##1 oversample64 == $past(clkCtl_ff[OSR_BIT]);
  endproperty
  a_osr: assert property (p_osr) else $error("oversample select wrong");
  property p_pd_now;
    @(posedge ref_clk) disable iff (!rst_b) s_pdWrite |=> ##1 refPowerDown && filterClear;
  endproperty
  a_pd_now: assert property (p_pd_now) else $error("power-down late");
  property p_keep_gain;
    @(posedge ref_clk) disable iff (!rst_b)
      globalPd && !(wrStrobe && wrAddr == ADDR_LEFT_GAIN) |=> gainL_ff == $past(gainL_ff);
  endproperty
  a_keep_gain: assert property (p_keep_gain) else $error("register lost in power-down");
  property p_reinit;
    @(posedge ref_clk) disable iff (!rst_b) s_pdRelease |=> !filterReady;
  endproperty
  a_reinit: assert property (p_reinit) else $error("output before filter init");
  property p_mute;
    @(posedge ref_clk) disable iff (!rst_b) muteLink_ff[MUTEL_BIT] |=> leftSilence;
  endproperty
  a_mute: assert property (p_mute) else $error("left mute ignored");
  property p_link;
    @(posedge ref_clk) disable iff (!rst_b)
      linkSel && !gainL_ff[ZC_BIT] && !gainR_ff[ZC_BIT] && wrL
      |=> ##2 giR.curCode == gainL_ff[7:0];
  endproperty
  a_link: assert property (p_link) else $error("right not following left");
  property p_hpf;
    @(posedge ref_clk) disable iff (!rst_b) ##1 highpassBypass == $past(filtCtl_ff[HPD_BIT]);
  endproperty
  a_hpf: assert property (p_hpf) else $error("high-pass bypass wrong");
  property p_slave_idle;
    @(posedge ref_clk) disable iff (!rst_b) !masterSel |=> !frameClkOut && !bitClkOut;
  endproperty
  a_slave_idle: assert property (p_slave_idle) else $error("slave drives clock value");
  property p_global_all;
    @(posedge ref_clk) disable iff (!rst_b)
      globalPd |=> refPowerDown && converterPowerDown && inputStagePowerDown;
  endproperty
  a_global_all: assert property (p_global_all) else $error("global power-down partial");
  property p_halt_clear;
    @(posedge ref_clk) disable iff (!rst_b) haltPath |=> filterClear && !filterReady;
  endproperty
  a_halt_clear: assert property (p_halt_clear) else $error("history kept while halted");
  property p_conv_off;
    @(posedge ref_clk) disable iff (!rst_b) convDis |=> converterPowerDown;
  endproperty
  a_conv_off: assert property (p_conv_off) else $error("converter disable ignored");
  property p_analog_range;
    @(posedge ref_clk) disable iff (!rst_b)
      giL.curCode >= GAIN_MIN_ANALOG |=> leftDigitalCode == 8'h00;
  endproperty
  a_analog_range: assert property (p_analog_range) else $error("attenuation in analog range");
  property p_code_mute;
    @(posedge ref_clk) disable iff (!rst_b) giL.curCode == GAIN_MUTE_CODE |=> leftSilence;
  endproperty
  a_code_mute: assert property (p_code_mute) else $error("mute code not silent");
  property p_mute_right;
    @(posedge ref_clk) disable iff (!rst_b) muteLink_ff[MUTER_BIT] |=> rightSilence;
  endproperty
  a_mute_right: assert property (p_mute_right) else $error("right mute ignored");
endmodule : agc_control

// ===== agc_control_test.sv
`timescale 1ns/10ps
module agc_control_test;
  import agc_pkg::*;
  localparam int TMO = 64;
  localparam int FINIT = 4;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] wrWord;
  logic wrStrobe;
  logic frameClkIn = 1'b0;
  logic bitClkIn = 1'b0;
  logic [23:0] leftSample = 24'h000000;
  logic [23:0] rightSample = 24'h000000;
  logic sampleValid = 1'b0;
  logic frameClkOut, frameClkOe, bitClkOut, bitClkOe, frameSync, bitClkSync;
  logic oversample64, refPowerDown, converterPowerDown, inputStagePowerDown;
  logic filterClear, filterReady, highpassBypass, leftSilence, rightSilence;
  logic [7:0] leftAnalogCode, rightAnalogCode, leftDigitalCode, rightDigitalCode;
  logic [7:0] lc, rc, c;
  logic [7:0] corner [6] = '{8'h00, 8'h01, 8'ha4, 8'ha5, 8'hcf, 8'hff};
  logic [15:0] n;
  logic osr;
  int failCount = 0;
  int cmpCount = 0;
  int cycles = 0;
  int ratio [4] = '{FS_DIV_256, FS_DIV_384, FS_DIV_512, FS_DIV_768};
  logic [2:0] rate [4] = '{RATE_256, RATE_384, RATE_512, RATE_768};

  agc_host_model host (.ref_clk, .wrWord, .wrStrobe);
  agc_control #(.TIMEOUT(TMO), .FILT_INIT(FINIT)) dut (
    .ref_clk, .rst_b, .wrWord, .wrStrobe, .frameClkIn, .bitClkIn, .leftSample,
    .rightSample, .sampleValid, .frameClkOut, .frameClkOe, .bitClkOut, .bitClkOe,
    .frameSync, .bitClkSync, .oversample64, .refPowerDown, .converterPowerDown,
    .inputStagePowerDown, .filterClear, .filterReady, .highpassBypass,
    .leftAnalogCode, .rightAnalogCode, .leftDigitalCode, .rightDigitalCode,
    .leftSilence, .rightSilence
  );

  always #12.5 ref_clk = ~ref_clk;

  // ****************
  // Checking helpers
  // ****************
  function automatic logic [7:0] expA(input logic [7:0] code);
    return (code >= GAIN_MIN_ANALOG) ? code - GAIN_MIN_ANALOG : 8'h00;
  endfunction : expA
  function automatic logic [7:0] expD(input logic [7:0] code);
    return (code < GAIN_MIN_ANALOG) ? GAIN_MIN_ANALOG - code : 8'h00;
  endfunction : expD
  task automatic chkBit(input logic got, input logic exp, input string what);
    cmpCount++;
    if (got !== exp) begin
      failCount++;
      $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chkBit
  task automatic chkVal(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmpCount++;
    if (got !== exp) begin
      failCount++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chkVal
  task automatic checkGain(input logic ml, input logic mr);
    chkVal(16'(leftAnalogCode), 16'(expA(lc)), "left analog");
    chkVal(16'(leftDigitalCode), 16'(expD(lc)), "left digital");
    chkVal(16'(rightAnalogCode), 16'(expA(rc)), "right analog");
    chkVal(16'(rightDigitalCode), 16'(expD(rc)), "right digital");
    chkBit(leftSilence, ml | (lc == GAIN_MUTE_CODE), "left silence");
    chkBit(rightSilence, mr | (rc == GAIN_MUTE_CODE), "right silence");
  endtask : checkGain
  task automatic wt(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : wt
  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    host.send(a, d, 1'b0, $urandom_range(2));
  endtask : wr
  task automatic smp(input logic neg);
    @(posedge ref_clk);
    leftSample <= {neg, 23'($urandom)};
    rightSample <= {neg, 23'($urandom)};
    sampleValid <= 1'b1;
    @(posedge ref_clk);
    sampleValid <= 1'b0;
  endtask : smp
  task automatic period(input bit useBit, output logic [15:0] cnt);
    logic prev;
    logic cur;
    int rises;
    rises = 0;
    cnt = 16'h0000;
    prev = 1'b1;
    for (int k = 0; k < 4000 && rises < 2; k++) begin
      @(posedge ref_clk);
      #1;
      cur = useBit ? bitClkOut : frameClkOut;
      if (rises == 1) cnt++;
      if (cur === 1'b1 && prev === 1'b0) rises++;
      prev = cur;
    end
  endtask : period
  task automatic printVerdict;
    $display("checks %0d mismatches %0d", cmpCount, failCount);
    if (failCount == 0 && cmpCount > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : printVerdict

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failCount++;
      $display("BAD %0t run timed out", $time);
      printVerdict();
    end
  end

  // ****************
  // Test sequence
  // ****************
  initial begin
    void'($urandom(32'h27985990));
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    lc = RST_GAIN[7:0];
    rc = RST_GAIN[7:0];
    wt(FINIT + 6);
    checkGain(1'b0, 1'b0);
    chkBit(frameClkOe, 1'b0, "oe after reset");
    chkBit(highpassBypass, 1'b0, "highpass at reset");
    chkBit(oversample64, 1'b0, "osr at reset");
    chkBit(filterReady, 1'b1, "filter ready");
    $display("test reset done");
    for (int i = 0; i < 14; i++) begin
      c = (i < 6) ? corner[i] : 8'($urandom);
      host.send(ADDR_LEFT_GAIN, {1'b0, c}, 1'b1, 0);
      host.send(ADDR_RIGHT_GAIN, {1'b0, ~c}, 1'b0, 0);
      lc = c;
      rc = ~c;
      wt(5);
      checkGain(1'b0, 1'b0);
    end
    $display("test gain map done");
    wr(ADDR_MUTE_LINK, 9'h080);
    wt(5);
    checkGain(1'b1, 1'b0);
    wr(ADDR_MUTE_LINK, 9'h040);
    wt(5);
    checkGain(1'b0, 1'b1);
    wr(ADDR_MUTE_LINK, 9'h100);
    wr(ADDR_LEFT_GAIN, 9'h060);
    wt(5);
    lc = 8'h60;
    chkVal(16'(rightAnalogCode), 16'(expA(lc)), "linked analog");
    chkVal(16'(rightDigitalCode), 16'(expD(lc)), "linked digital");
    wr(ADDR_MUTE_LINK, 9'h000);
    wr(7'h10, 9'h1ff);
    wr(7'h7f, 9'h1ff);
    wt(5);
    checkGain(1'b0, 1'b0);
    chkBit(frameClkOe, 1'b0, "unmapped write");
    wr(ADDR_FILTER, 9'h100);
    wt(4);
    chkBit(highpassBypass, 1'b1, "highpass bypass");
    $display("test mute link filter done");
    for (int i = 0; i < 4; i++) begin
      osr = 1'($urandom);
      wr(ADDR_CLOCKING, {1'b1, 4'h0, osr, rate[i]});
      wt(4);
      chkBit(frameClkOe, 1'b1, "frame oe");
      chkBit(bitClkOe, 1'b1, "bit oe");
      chkBit(oversample64, osr, "osr");
      period(1'b0, n);
      chkVal(n, 16'(ratio[i]), "frame period");
      period(1'b1, n);
      chkVal(n, 16'(ratio[i] / BCLK_PER_FRAME), "bit period");
    end
    $display("test master clocks done");
    wr(ADDR_POWER, 9'h042);
    wt(4);
    chkBit(converterPowerDown, 1'b1, "converter off");
    chkBit(inputStagePowerDown, 1'b1, "input off");
    chkBit(refPowerDown, 1'b0, "ref on");
    chkBit(filterReady, 1'b0, "filter halted");
    wr(ADDR_POWER, 9'h001);
    wt(4);
    chkBit(refPowerDown, 1'b1, "ref off");
    chkBit(converterPowerDown, 1'b1, "override conv");
    chkBit(inputStagePowerDown, 1'b1, "override input");
    chkBit(filterClear, 1'b1, "history cleared");
    // Held divider parks both pins: no edge at all may appear
    period(1'b0, n);
    chkVal(n, 16'h0000, "frame divider held");
    period(1'b1, n);
    chkVal(n, 16'h0000, "bit divider held");
    checkGain(1'b0, 1'b0);
    wr(ADDR_POWER, 9'h000);
    wt(FINIT + 6);
    chkBit(filterReady, 1'b1, "filter reinit");
    chkBit(filterClear, 1'b0, "clear released");
    wr(ADDR_CLOCKING, RST_CLOCKING);
    wt(4);
    chkBit(frameClkOe, 1'b0, "slave oe");
    for (int v = 0; v < 2; v++) begin
      @(posedge ref_clk);
      frameClkIn <= ~1'(v);
      bitClkIn <= 1'(v);
      wt(5);
      chkBit(frameSync, ~1'(v), "slave frame");
      chkBit(bitClkSync, 1'(v), "slave bit");
    end
    $display("test power slave done");
    wr(ADDR_ZC_TIMEOUT, 9'h008);
    wr(ADDR_LEFT_GAIN, 9'h090);
    wr(ADDR_RIGHT_GAIN, 9'h0d0);
    lc = 8'h90;
    rc = 8'hd0;
    smp(1'b0);
    wr(ADDR_LEFT_GAIN, 9'h1c0);
    smp(1'b0);
    smp(1'b0);
    wt(4);
    checkGain(1'b0, 1'b0);
    smp(1'b1);
    wt(4);
    lc = 8'hc0;
    checkGain(1'b0, 1'b0);
    wr(ADDR_LEFT_GAIN, 9'h1f0);
    wt(TMO + 30);
    checkGain(1'b0, 1'b0);
    smp(1'b0);
    wt(4);
    lc = 8'hf0;
    checkGain(1'b0, 1'b0);
    wr(ADDR_ZC_TIMEOUT, 9'h000);
    wr(ADDR_LEFT_GAIN, 9'h1a0);
    wt(40);
    wr(ADDR_LEFT_GAIN, 9'h1b0);
    wt(40);
    checkGain(1'b0, 1'b0);
    wt(34);
    lc = 8'hb0;
    checkGain(1'b0, 1'b0);
    wr(ADDR_RIGHT_GAIN, 9'h1e0);
    wt(10);
    checkGain(1'b0, 1'b0);
    smp(1'b1);
    wt(4);
    rc = 8'he0;
    checkGain(1'b0, 1'b0);
    $display("test zero cross done");
    printVerdict();
  end
endmodule : agc_control_test

// ===== agc_gain_if.sv
`timescale 1ns/10ps
interface agc_gain_if;
  logic [7:0] reqCode;
  logic reqLoad;
  logic reqZc;
  logic timeoutDis;
  logic [23:0] sample;
  logic sampleValid;
  logic [7:0] curCode;
  logic pending;
  modport ctl (output reqCode, reqLoad, reqZc, timeoutDis, sample, sampleValid,
               input curCode, pending);
  modport chan (input reqCode, reqLoad, reqZc, timeoutDis, sample, sampleValid,
                output curCode, pending);
endinterface : agc_gain_if

// ===== agc_host_model.sv
`timescale 1ns/10ps
module agc_host_model (
  input wire logic ref_clk,
  output logic [15:0] wrWord,
  output logic wrStrobe
);
  // ****************
  // Write driver
  // ****************
  initial begin
    wrWord = 16'h0000;
    wrStrobe = 1'b0;
  end
  // Keep holds strobe for a back-to-back burst; idle models a slow host
  task automatic send(input logic [6:0] addr, input logic [8:0] data, input bit keep,
                      input int idle);
    @(posedge ref_clk);
    wrWord <= {addr, data};
    wrStrobe <= 1'b1;
    if (!keep) begin
      @(posedge ref_clk);
      wrStrobe <= 1'b0;
      // Released word shows garbage, not the last value
      wrWord <= ~{addr, data};
      repeat (idle) @(posedge ref_clk);
    end
  endtask : send
endmodule : agc_host_model

// ===== agc_pkg.sv
package agc_pkg;
  // ****************************************
  // Register map (7-bit addresses)
  // ****************************************
  localparam logic [6:0] ADDR_ZC_TIMEOUT = 7'h07;
  localparam logic [6:0] ADDR_FILTER = 7'h0b;
  localparam logic [6:0] ADDR_CLOCKING = 7'h0c;
  localparam logic [6:0] ADDR_POWER = 7'h0d;
  localparam logic [6:0] ADDR_LEFT_GAIN = 7'h0e;
  localparam logic [6:0] ADDR_RIGHT_GAIN = 7'h0f;
  localparam logic [6:0] ADDR_MUTE_LINK = 7'h15;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int TOD_BIT = 3;
  localparam int HPD_BIT = 8;
  localparam int MS_BIT = 8;
  localparam int OSR_BIT = 3;
  localparam int RATE_LSB = 0;
  localparam int GLOBAL_POWERDOWN_BIT = 0;
  localparam int CONVERTER_DISABLE_BIT = 1;
  localparam int INPUT_STAGE_DISABLE_BIT = 6;
  localparam int ZC_BIT = 8;
  localparam int LINK_BIT = 8;
  localparam int MUTEL_BIT = 7;
  localparam int MUTER_BIT = 6;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [8:0] RST_ZC_TIMEOUT = 9'h000;
  localparam logic [8:0] RST_FILTER = 9'h000;
  localparam logic [8:0] RST_CLOCKING = 9'h002;
  localparam logic [8:0] RST_POWER = 9'h000;
  localparam logic [8:0] RST_GAIN = 9'h0cf;
  localparam logic [8:0] RST_MUTE_LINK = 9'h000;
  // ****************************************
  // Gain map and ratios
  // ****************************************
  localparam logic [7:0] GAIN_MIN_ANALOG = 8'ha5;
  localparam logic [7:0] GAIN_MUTE_CODE = 8'h00;
  localparam logic [2:0] RATE_256 = 3'h2;
  localparam logic [2:0] RATE_384 = 3'h3;
  localparam logic [2:0] RATE_512 = 3'h4;
  localparam logic [2:0] RATE_768 = 3'h5;
  localparam int FS_DIV_256 = 256;
  localparam int FS_DIV_384 = 384;
  localparam int FS_DIV_512 = 512;
  localparam int FS_DIV_768 = 768;
  localparam int BCLK_PER_FRAME = 64;
  localparam int ZC_TIMEOUT_MCLKS = 131072;
  localparam int FILT_INIT_CYCLES = 16;
  localparam int SAMPLE_W = 24;
endpackage : agc_pkg

// ===== agc_zc_channel.sv
`timescale 1ns/10ps
module agc_zc_channel
  import agc_pkg::*;
#(
  parameter int TIMEOUT = ZC_TIMEOUT_MCLKS
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  agc_gain_if.chan gi
);
  logic [7:0] curCode_ff;
  logic [7:0] pendCode_ff;
  logic pending_ff;
  logic [17:0] toCnt_ff;
  logic lastSign_ff;
  logic zcHit;
  logic toHit;

  // Sign change between consecutive samples marks a crossing
  assign zcHit = gi.sampleValid && (gi.sample[SAMPLE_W-1] != lastSign_ff);
  assign toHit = !gi.timeoutDis && (toCnt_ff >= 18'(TIMEOUT - 1));

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      lastSign_ff <= 1'b0;
    end else if (gi.sampleValid) begin
      lastSign_ff <= gi.sample[SAMPLE_W-1];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      curCode_ff <= RST_GAIN[7:0];
      pendCode_ff <= RST_GAIN[7:0];
      pending_ff <= 1'b0;
    end else if (gi.reqLoad && !gi.reqZc) begin
      curCode_ff <= gi.reqCode;
      pending_ff <= 1'b0;
    end else if (gi.reqLoad) begin
      pendCode_ff <= gi.reqCode;
      pending_ff <= 1'b1;
    end else if (pending_ff && (zcHit || toHit)) begin
      curCode_ff <= pendCode_ff;
      pending_ff <= 1'b0;
    end
  end

  // Counter restarts on each deferred write, cleared on apply
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      toCnt_ff <= '0;
    end else if (gi.reqLoad || !pending_ff || zcHit || toHit) begin
      toCnt_ff <= '0;
    end else begin
      toCnt_ff <= toCnt_ff + 18'h1;
    end
  end

  assign gi.curCode = curCode_ff;
  assign gi.pending = pending_ff;

  property p_timeout_apply;
    @(posedge ref_clk) disable iff (!rst_b)
      pending_ff && toHit && !gi.reqLoad |=> !pending_ff && curCode_ff == $past(pendCode_ff);
  endproperty
  a_timeout_apply: assert property (p_timeout_apply)
    else $error("timeout did not apply pending gain");
  property p_no_force_when_dis;
    @(posedge ref_clk) disable iff (!rst_b)
      pending_ff && gi.timeoutDis && !zcHit && !gi.reqLoad |=> pending_ff;
  endproperty
  a_no_force_when_dis: assert property (p_no_force_when_dis)
    else $error("update forced with timeout disabled");
  property p_zc_apply;
    @(posedge ref_clk) disable iff (!rst_b)
      pending_ff && zcHit && !gi.reqLoad |=> curCode_ff == $past(pendCode_ff);
  endproperty
  a_zc_apply: assert property (p_zc_apply)
    else $error("crossing did not apply gain");
endmodule : agc_zc_channel
